// File: core/hcp_host_port.sv
// host control port: serial and parallel register access front end
`timescale 1ns/1ps
`default_nettype none
module hcp_host_port
    import hcp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control pins (strobe is data strobe or read strobe, sdi_dir is
    // serial input, direction or write strobe)
    input wire hcp_ctl_t ctl_pins,
    // parallel address and data bus
    input wire logic [HCP_ADDR_W-1:0] addr_pins,
    input wire logic [HCP_DATA_W-1:0] data_in,
    output logic [HCP_DATA_W-1:0] data_out,
    output logic data_oe_n,
    // serial output line
    output logic serial_output_line,
    output logic serial_output_oe_n,
    // register access towards the device core
    output logic [HCP_ADDR_W-1:0] reg_addr,
    output logic [HCP_DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [HCP_DATA_W-1:0] reg_rdata
);
    localparam int SYNC_W = HCP_CTL_W + HCP_ADDR_W + HCP_DATA_W;

    hcp_ctl_t ctl_s;
    logic [HCP_ADDR_W-1:0] addr_s;
    logic [HCP_DATA_W-1:0] data_s;

    hcp_sync #(
        .W(SYNC_W),
        .RST_VAL({HCP_CTL_IDLE, HCP_BYTE_RST, HCP_BYTE_RST})
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({ctl_pins, addr_pins, data_in}),
        .sync_out({ctl_s, addr_s, data_s})
    );

    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    function automatic logic fall(input logic cur, input logic prev);
        return ~cur & prev;
    endfunction

    hcp_ctl_t prev_reg, prev_next;
    hcp_state_t st_reg, st_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [16:0] sh_reg, sh_next;
    logic [7:0] out_sh_reg, out_sh_next;
    logic sdo_reg, sdo_next;
    logic rd_act_reg, rd_act_next;
    logic drive_reg, drive_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wr_reg, wr_next;
    logic rd_reg, rd_next;

    logic sel;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic launch;
    logic strobe_fall;
    logic strobe_rise;
    logic dir_rise;
    logic single_strobe;
    logic [16:0] sh_shift;
    logic [4:0] cnt_inc;

    always_comb
    begin
        sel = ~ctl_s.cs_n;
        cs_fall = fall(ctl_s.cs_n, prev_reg.cs_n);
        sclk_rise = rise(ctl_s.shift_clk, prev_reg.shift_clk);
        sclk_fall = fall(ctl_s.shift_clk, prev_reg.shift_clk);
        launch = ctl_s.output_edge_select ? sclk_fall : sclk_rise;
        strobe_fall = fall(ctl_s.strobe, prev_reg.strobe);
        strobe_rise = rise(ctl_s.strobe, prev_reg.strobe);
        dir_rise = rise(ctl_s.sdi_dir, prev_reg.sdi_dir);
        single_strobe = ~ctl_s.bus_style_select;
        sh_shift = {sh_reg[15:0], ctl_s.sdi_dir};
        cnt_inc = cnt_reg + 5'h01;

        prev_next = ctl_s;
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        out_sh_next = out_sh_reg;
        sdo_next = sdo_reg;
        rd_act_next = rd_act_reg;
        drive_next = drive_reg;
        rd_data_next = rd_data_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        wr_next = 1'b0;
        rd_next = 1'b0;

        // read data sampled in the cycle the read pulse is out
        if (rd_reg)
        begin
            rd_data_next = reg_rdata;
            out_sh_next = reg_rdata;
        end

        case (st_reg)
            HCP_IDLE:
            begin
                // arm only on a fresh select fall
                if (cs_fall)
                begin
                    st_next = HCP_ARMED;
                    cnt_next = HCP_CNT_RST;
                    sh_next = HCP_SHIFT_RST;
                end
            end
            HCP_ARMED:
            begin
                if (!ctl_s.port_style_select)
                begin
                    if (sclk_rise)
                    begin
                        sh_next = sh_shift;
                        cnt_next = cnt_inc;
                        if (cnt_inc == HCP_SER_CMD_BITS && sh_shift[HCP_SER_DIR_POS])
                        begin
                            addr_next = sh_shift[7:0];
                            rd_next = 1'b1;
                            rd_act_next = 1'b1;
                        end
                        if (cnt_inc == HCP_SER_FRAME_BITS)
                        begin
                            st_next = HCP_DONE;
                            if (!sh_shift[16])
                            begin
                                addr_next = sh_shift[15:8];
                                wdata_next = sh_shift[7:0];
                                wr_next = 1'b1;
                            end
                        end
                    end
                    // shift read data out on launch edge
                    if (launch && rd_act_reg && !rd_reg)
                    begin
                        sdo_next = out_sh_reg[7];
                        out_sh_next = {out_sh_reg[6:0], 1'b0};
                    end
                end
                else if (!rd_act_reg)
                begin
                    // single strobe read when direction is 1
                    if (strobe_fall && (ctl_s.sdi_dir || !single_strobe))
                    begin
                        addr_next = addr_s;
                        rd_next = 1'b1;
                        rd_act_next = 1'b1;
                    end
                    // single strobe write when direction is 0
                    else if (single_strobe && strobe_rise && !ctl_s.sdi_dir)
                    begin
                        addr_next = addr_s;
                        wdata_next = data_s;
                        wr_next = 1'b1;
                        st_next = HCP_DONE;
                    end
                    else if (!single_strobe && dir_rise)
                    begin
                        addr_next = addr_s;
                        wdata_next = data_s;
                        wr_next = 1'b1;
                        st_next = HCP_DONE;
                    end
                end
                else
                begin
                    // bus driven from captured data until strobe ends
                    if (rd_reg)
                    begin
                        drive_next = 1'b1;
                    end
                    if (strobe_rise)
                    begin
                        drive_next = 1'b0;
                        st_next = HCP_DONE;
                    end
                end
            end
            HCP_DONE:
            begin
                drive_next = 1'b0;
            end
            default:
            begin
                st_next = HCP_IDLE;
            end
        endcase

        // select high ends the access and blocks the read and write pulses
        if (!sel)
        begin
            st_next = HCP_IDLE;
            drive_next = 1'b0;
            rd_act_next = 1'b0;
            wr_next = 1'b0;
            rd_next = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_reg <= HCP_CTL_IDLE;
            st_reg <= HCP_IDLE;
            cnt_reg <= HCP_CNT_RST;
            sh_reg <= HCP_SHIFT_RST;
            out_sh_reg <= HCP_BYTE_RST;
            sdo_reg <= 1'b0;
            rd_act_reg <= 1'b0;
            drive_reg <= 1'b0;
            rd_data_reg <= HCP_BYTE_RST;
            addr_reg <= HCP_BYTE_RST;
            wdata_reg <= HCP_BYTE_RST;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= prev_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            out_sh_reg <= out_sh_next;
            sdo_reg <= sdo_next;
            rd_act_reg <= rd_act_next;
            drive_reg <= drive_next;
            rd_data_reg <= rd_data_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    assign data_out = rd_data_reg;
    assign data_oe_n = ~drive_reg;
    assign serial_output_line = sdo_reg;
    assign serial_output_oe_n = ~(rd_act_reg & ~ctl_s.port_style_select);
    assign reg_addr = addr_reg;
    assign reg_wdata = wdata_reg;
    assign reg_wr = wr_reg;
    assign reg_rd = rd_reg;
endmodule
`default_nettype wire

// File: core/hcp_pkg.sv
// shared constants and pin groups for the host control port
package hcp_pkg;
    localparam int HCP_ADDR_W = 8;
    localparam int HCP_DATA_W = 8;
    // serial frame: direction bit, address byte, data byte (msb first)
    localparam logic [4:0] HCP_SER_CMD_BITS = 5'h09;
    localparam logic [4:0] HCP_SER_FRAME_BITS = 5'h11;
    localparam int HCP_SER_DIR_POS = 8;
    localparam logic [7:0] HCP_BYTE_RST = 8'h00;
    localparam logic [4:0] HCP_CNT_RST = 5'h00;
    localparam logic [16:0] HCP_SHIFT_RST = 17'h0_0000;
    // control pins of the port, raw or synchronised
    typedef struct packed {
        logic cs_n;
        logic shift_clk;
        logic sdi_dir;
        logic strobe;
        logic output_edge_select;
        logic port_style_select;
        logic bus_style_select;
    } hcp_ctl_t;
    localparam int HCP_CTL_W = $bits(hcp_ctl_t);
    localparam hcp_ctl_t HCP_CTL_IDLE = 7'h78;
    typedef enum logic [1:0] {HCP_IDLE, HCP_ARMED, HCP_DONE} hcp_state_t;
endpackage

// File: core/hcp_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module hcp_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pins in, synchronised out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: tb/hcp_monitor.sv
// checker for the host control port
`timescale 1ns/1ps
`default_nettype none
module hcp_monitor
    import hcp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // watched ports
    input wire hcp_ctl_t ctl_pins,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    input wire logic serial_output_line,
    input wire logic serial_output_oe_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // pin history, h[k] is k edges old
    hcp_ctl_t h [1:6];
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clock)
    begin
        h[1] <= ctl_pins;
        for (int i = 2; i < 7; i++)
            h[i] <= h[i-1];
    end
    property p_quiet; reg_wr || reg_rd |-> !h[2].cs_n && !h[6].cs_n; endproperty
    a_quiet: assert property (p_quiet) else $error("pulse without select");
    property p_rd; reg_rd && h[2].port_style_select
        |-> !h[2].strobe && h[6].strobe && (h[2].bus_style_select || h[2].sdi_dir); endproperty
    a_rd: assert property (p_rd) else $error("read pulse without read strobe");
    property p_wr1; reg_wr && h[2].port_style_select && !h[2].bus_style_select
        |-> h[2].strobe && !h[6].strobe && !h[2].sdi_dir; endproperty
    a_wr1: assert property (p_wr1) else $error("bad single strobe write");
    property p_wr2; reg_wr && h[2].port_style_select && h[2].bus_style_select
        |-> h[2].sdi_dir && !h[6].sdi_dir && h[2].strobe; endproperty
    a_wr2: assert property (p_wr2) else $error("bad write strobe write");
    property p_drive; $fell(data_oe_n) |-> $past(reg_rd) && data_out == $past(reg_rdata); endproperty
    a_drive: assert property (p_drive) else $error("bus driven with wrong data");
    property p_port; !data_oe_n |-> h[4].port_style_select && !h[4].cs_n; endproperty
    a_port: assert property (p_port) else $error("bus driven outside parallel access");
    property p_ser_wr; reg_wr && !h[2].port_style_select |-> h[2].shift_clk && !h[6].shift_clk; endproperty
    a_ser_wr: assert property (p_ser_wr) else $error("serial write off rising shift");
    property p_ser_out; $changed(serial_output_line) && !serial_output_oe_n && !$past(serial_output_oe_n)
        && !$past(reg_rd) && !$past(reg_rd, 2) |-> h[2].shift_clk != h[2].output_edge_select; endproperty
    a_ser_out: assert property (p_ser_out) else $error("serial output on wrong edge");
    property p_ser_oe; $fell(serial_output_oe_n) |-> reg_rd && !h[2].port_style_select && !h[2].cs_n; endproperty
    a_ser_oe: assert property (p_ser_oe) else $error("serial output enabled without serial read");
endmodule
bind hcp_host_port hcp_monitor mon (.clock, .rst_n, .ctl_pins, .data_out, .data_oe_n, .serial_output_line,
    .serial_output_oe_n, .reg_wr, .reg_rd, .reg_rdata);
`default_nettype wire

// File: tb/hcp_host_model.sv
// host microcontroller model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module hcp_host_model
    import hcp_pkg::*;
(
    // clock
    input wire logic clock,
    // pins towards the port
    output var hcp_ctl_t ctl_pins,
    output var logic [7:0] addr_pins,
    output logic [7:0] data_in,
    // pins from the port
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    input wire logic serial_output_line
);
    logic [7:0] wv = 8'h00;
    logic drv = 1'b0;
    initial ctl_pins = HCP_CTL_IDLE;
    initial addr_pins = 8'h00;
    // released bus shows the inverse of the last value
    assign data_in = !data_oe_n ? data_out : drv ? wv : ~wv;
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic par(input logic sel, bs, wr, input logic [7:0] a, d, output logic [7:0] q);
        ctl_pins.port_style_select <= 1'b1;
        ctl_pins.bus_style_select <= bs;
        ctl_pins.sdi_dir <= bs | !wr;
        addr_pins <= a;
        wv <= d;
        drv <= wr;
        tk(4);
        ctl_pins.cs_n <= !sel;
        tk(4);
        if (wr && bs)
            ctl_pins.sdi_dir <= 1'b0;
        else
            ctl_pins.strobe <= 1'b0;
        tk(8);
        q = data_in;
        ctl_pins.sdi_dir <= bs | !wr;
        ctl_pins.strobe <= 1'b1;
        tk(4);
        ctl_pins.cs_n <= 1'b1;
        drv <= 1'b0;
        tk(4);
    endtask
    task automatic ser(input logic oes, input logic [16:0] f, output logic [7:0] q);
        ctl_pins.port_style_select <= 1'b0;
        ctl_pins.output_edge_select <= oes;
        ctl_pins.shift_clk <= 1'b0;
        tk(4);
        ctl_pins.cs_n <= 1'b0;
        for (int i = 16; i >= 0; i--)
        begin
            ctl_pins.sdi_dir <= f[i];
            tk(4);
            if (oes && i < 8)
                q[i] = serial_output_line;
            ctl_pins.shift_clk <= 1'b1;
            tk(4);
            if (!oes && i < 8)
                q[i] = serial_output_line;
            ctl_pins.shift_clk <= 1'b0;
        end
        tk(4);
        ctl_pins.cs_n <= 1'b1;
        tk(4);
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the host control port
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hcp_pkg::*;
;
    // port, bus style, write, output edge, address, data
    typedef struct packed { logic p, bs, wr, oes; logic [7:0] a, d; } hcp_row_t;
    hcp_row_t rows [8] = '{20'hA_00FF, 20'h8_3C00, 20'hE_FF81, 20'hC_A5FF,
        20'h2_1234, 20'h0_7E00, 20'h1_0100, 20'h3_C35A};
    hcp_row_t r;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    hcp_ctl_t ctl_pins;
    logic [7:0] addr_pins, data_in, data_out, reg_addr, reg_wdata, reg_rdata, q;
    logic data_oe_n, serial_output_line, serial_output_oe_n, reg_wr, reg_rd;
    int failures = 0, tests_run = 0, nw = 0, nr = 0, w0, r0;
    always #50 clock = ~clock;
    assign reg_rdata = reg_addr ^ 8'h5a;
    always @(posedge clock)
    begin
        nw += reg_wr;
        nr += reg_rd;
    end
    hcp_host_port dut (.clock, .rst_n, .ctl_pins, .addr_pins, .data_in, .data_out, .data_oe_n,
        .serial_output_line, .serial_output_oe_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    hcp_host_model m (.clock, .ctl_pins, .addr_pins, .data_in, .data_out, .data_oe_n, .serial_output_line);
    task automatic chk(input string n, input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // about 780 cycles expected
    initial
    begin
        repeat (6000) @(posedge clock);
        failures++;
        complete_run();
    end
    initial
    begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            r = rows[i];
            w0 = nw;
            r0 = nr;
            if (r.p)
                m.par(1'b1, r.bs, r.wr, r.a, r.d, q);
            else
                m.ser(r.oes, {!r.wr, r.a, r.d}, q);
            chk("addr", reg_addr, r.a);
            chk("wr pulses", 8'(nw - w0), {7'h00, r.wr});
            chk("rd pulses", 8'(nr - r0), {7'h00, !r.wr});
            if (r.wr)
                chk("wdata", reg_wdata, r.d);
            else
                chk("rdata", q, r.a ^ 8'h5a);
            chk("released", {6'h00, data_oe_n, serial_output_oe_n}, 8'h03);
        end
        w0 = nw;
        r0 = nr;
        m.par(1'b0, 1'b0, 1'b1, 8'h66, 8'h99, q);
        m.par(1'b0, 1'b1, 1'b0, 8'h77, 8'h00, q);
        chk("idle pulses", 8'(nw - w0 + nr - r0), 8'h00);
        chk("idle addr", reg_addr, r.a);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk("reset addr", reg_addr, 8'h00);
        chk("reset outs", {4'h0, data_oe_n, serial_output_oe_n, reg_wr, reg_rd}, 8'h0c);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        m.par(1'b1, 1'b1, 1'b0, 8'h42, 8'h00, q);
        chk("rdata after reset", q, 8'h18);
        complete_run();
    end
endmodule
`default_nettype wire
